// *** rtl/i2c_slave_bus_recovery.sv ***
// Function
// - write 29, burst 20+9N, read 39 bits
// - accept several data bytes per write
// - any start resets the interface machine
// - held-low data line blocks master start
// - read nack releases bus and resets machine
// - recovery resets interface only, not register
// - stop commits pending write, start aborts it
// - after stop stay idle until start
// - acknowledge own address byte by pulling low
`timescale 1ns/1ps
module i2c_slave_bus_recovery (
	// system side
	input  wire logic                          clk_i,
	input  wire logic                          reset_n_i,
	// bus sampling clock
	input  wire logic                          link_clk_i,
	// serial bus pins, data line is open drain
	input  wire logic                          scl_i,
	input  wire logic                          sda_i,
	output logic                               sda_o,
	output logic                               sda_oe_n_o,
	// volatile output register
	output logic [dac_i2c_pkg::DAC_W-1:0]      dac_value_o,
	output logic                               dac_update_o
);
	import dac_i2c_pkg::*;

	// ---------------- link domain ----------------
	logic              scl_s;
	logic              sda_s;
	logic              scl_d;
	logic              sda_d;
	logic              start_det;
	logic              stop_det;
	logic              scl_rise;
	logic              scl_fall;
	logic              byte_in_done;
	logic              wdata_done;
	logic              commit_now;
	link_state_t       state;
	logic [3:0]        bit_cnt;
	logic [7:0]        shift_in;
	logic [7:0]        shift_out;
	logic              read_dir;
	logic              pend_valid;
	logic [DAC_W-1:0]  pend_data;
	logic [DAC_W-1:0]  wr_hold;
	logic              wr_tog;
	logic [7:0]        read_byte;

	// the pins are asynchronous to the sampling clock
	line_sync #(.RESET_VAL(LINE_IDLE)) u_scl_sync (
		.clk_i     (link_clk_i),
		.reset_n_i (reset_n_i),
		.d_i       (scl_i),
		.q_o       (scl_s)
	);

	line_sync #(.RESET_VAL(LINE_IDLE)) u_sda_sync (
		.clk_i     (link_clk_i),
		.reset_n_i (reset_n_i),
		.d_i       (sda_i),
		.q_o       (sda_s)
	);

	always_ff @(posedge link_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			scl_d <= LINE_IDLE;
			sda_d <= LINE_IDLE;
		end else begin
			scl_d <= scl_s;
			sda_d <= sda_s;
		end
	end

	// data edges with the clock high on both samples are start and stop
	assign start_det = scl_s && scl_d && sda_d && !sda_s;
	assign stop_det  = scl_s && scl_d && !sda_d && sda_s;
	assign scl_rise  = scl_s && !scl_d;
	assign scl_fall  = !scl_s && scl_d;

	assign byte_in_done = scl_fall && (bit_cnt == BYTE_BITS);
	assign wdata_done   = (state == ST_WDATA) && byte_in_done;

	// a held byte is written out by the stop, or by the arrival of the next
	// byte in a burst; only a start can throw it away
	assign commit_now = pend_valid && (stop_det || wdata_done);

	// register contents zero-extended to a bus byte for reads
	assign read_byte = {{(8 - DAC_W){1'b0}}, wr_hold};

	// interface state machine; every start restarts it at the address byte,
	// which is what lets the master's recovery sequence bring it back
	always_ff @(posedge link_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state      <= ST_IDLE;
			bit_cnt    <= CNT_RESET;
			shift_in   <= 8'h00;
			shift_out  <= 8'h00;
			read_dir   <= 1'b0;
			sda_oe_n_o <= 1'b1;
		end else if (start_det) begin
			state      <= ST_ADDR;
			bit_cnt    <= CNT_RESET;
			sda_oe_n_o <= 1'b1;
		end else if (stop_det) begin
			state      <= ST_IDLE;
			sda_oe_n_o <= 1'b1;
		end else begin
			case (state)
				ST_IDLE: begin
					// bus traffic is ignored until the next start
					sda_oe_n_o <= 1'b1;
				end
				ST_ADDR, ST_CMD, ST_WDATA: begin
					if (scl_rise) begin
						shift_in <= {shift_in[6:0], sda_s};
						bit_cnt  <= bit_cnt + 4'h1;
					end else if (byte_in_done) begin
						if (state == ST_ADDR) begin
							if (shift_in[7:1] == SLAVE_ADDR) begin
								sda_oe_n_o <= 1'b0;
								read_dir   <= shift_in[0];
								state      <= ST_ADDR_ACK;
							end else begin
								state <= ST_IDLE;
							end
						end else if (state == ST_CMD) begin
							sda_oe_n_o <= 1'b0;
							state      <= ST_CMD_ACK;
						end else begin
							sda_oe_n_o <= 1'b0;
							state      <= ST_WDATA_ACK;
						end
					end
				end
				ST_ADDR_ACK: begin
					if (scl_fall) begin
						bit_cnt <= CNT_RESET;
						if (read_dir) begin
							shift_out  <= read_byte;
							sda_oe_n_o <= read_byte[7];
							state      <= ST_RDATA;
						end else begin
							sda_oe_n_o <= 1'b1;
							state      <= ST_CMD;
						end
					end
				end
				ST_CMD_ACK, ST_WDATA_ACK: begin
					// after the command byte every further byte is data
					if (scl_fall) begin
						bit_cnt    <= CNT_RESET;
						sda_oe_n_o <= 1'b1;
						state      <= ST_WDATA;
					end
				end
				ST_RDATA: begin
					if (scl_fall) begin
						if (bit_cnt == LAST_BIT) begin
							sda_oe_n_o <= 1'b1;
							state      <= ST_RD_ACK;
						end else begin
							shift_out  <= {shift_out[6:0], 1'b0};
							sda_oe_n_o <= shift_out[6];
							bit_cnt    <= bit_cnt + 4'h1;
						end
					end
				end
				ST_RD_ACK: begin
					if (scl_rise && sda_s) begin
						// nack: let go of the bus and wait for a start
						sda_oe_n_o <= 1'b1;
						state      <= ST_IDLE;
					end else if (scl_fall) begin
						bit_cnt    <= CNT_RESET;
						shift_out  <= read_byte;
						sda_oe_n_o <= read_byte[7];
						state      <= ST_RDATA;
					end
				end
				default: begin
					sda_oe_n_o <= 1'b1;
					state      <= ST_IDLE;
				end
			endcase
		end
	end

	// open drain: the pin only ever pulls low
	assign sda_o = 1'b0;

	// received data byte waiting for its stop
	always_ff @(posedge link_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pend_valid <= 1'b0;
			pend_data  <= DAC_RESET;
		end else if (start_det || stop_det) begin
			pend_valid <= 1'b0;
		end else if (wdata_done) begin
			pend_valid <= 1'b1;
			pend_data  <= shift_in[DAC_W-1:0];
		end
	end

	// committed value and the toggle announcing it; the state machine reset
	// never touches these, so recovery keeps the register contents
	always_ff @(posedge link_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wr_hold <= DAC_RESET;
			wr_tog  <= 1'b0;
		end else if (commit_now) begin
			wr_hold <= pend_data;
			wr_tog  <= !wr_tog;
		end
	end

	// ---------------- system domain ----------------
	logic tog_s;
	logic tog_d;

	// wr_hold stays still for at least a bit time after each toggle, far
	// longer than the three system clocks needed to take it
	line_sync #(.RESET_VAL(1'b0)) u_tog_sync (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.d_i       (wr_tog),
		.q_o       (tog_s)
	);

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tog_d <= 1'b0;
		end else begin
			tog_d <= tog_s;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			dac_value_o  <= DAC_RESET;
			dac_update_o <= 1'b0;
		end else begin
			dac_update_o <= tog_s ^ tog_d;
			if (tog_s ^ tog_d) begin
				dac_value_o <= wr_hold;
			end
		end
	end

endmodule

// *** rtl/line_sync.sv ***
`timescale 1ns/1ps
module line_sync #(
	parameter logic RESET_VAL = 1'b0
) (
	// clock and reset of the receiving domain
	input  wire logic clk_i,
	input  wire logic reset_n_i,
	// asynchronous level in, synchronised level out
	input  wire logic d_i,
	output logic      q_o
);

	logic meta;

	// first stage feeds only the second stage
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			meta <= RESET_VAL;
			q_o  <= RESET_VAL;
		end else begin
			meta <= d_i;
			q_o  <= meta;
		end
	end

endmodule

// *** shared/dac_i2c_pkg.sv ***
package dac_i2c_pkg;

	// width of the volatile output register
	localparam int              DAC_W      = 7;
	// register value after power-on or brown-out reset
	localparam logic [6:0]      DAC_RESET  = 7'h00;
	// seven-bit bus address this slave answers to
	localparam logic [6:0]      SLAVE_ADDR = 7'h2A;
	// bits in one bus byte, before the acknowledge slot
	localparam logic [3:0]      BYTE_BITS  = 4'h8;
	// last data bit index while shifting a byte out
	localparam logic [3:0]      LAST_BIT   = 4'h7;
	// bit counter value on entry to a byte
	localparam logic [3:0]      CNT_RESET  = 4'h0;
	// synchroniser stage value after reset (bus lines idle high)
	localparam logic            LINE_IDLE  = 1'b1;

	typedef enum logic [3:0] {
		ST_IDLE      = 4'h0,
		ST_ADDR      = 4'h1,
		ST_ADDR_ACK  = 4'h2,
		ST_CMD       = 4'h3,
		ST_CMD_ACK   = 4'h4,
		ST_WDATA     = 4'h5,
		ST_WDATA_ACK = 4'h6,
		ST_RDATA     = 4'h7,
		ST_RD_ACK    = 4'h8
	} link_state_t;

endpackage

// *** test/dac_i2c_checker_sva.sv ***
`timescale 1ns/1ps
module dac_i2c_checker
	import dac_i2c_pkg::*;
(
	// clocks and reset
	input wire logic             clk_i,
	input wire logic             reset_n_i,
	input wire logic             link_clk_i,
	// bus pins and register
	input wire logic             scl_i,
	input wire logic             sda_i,
	input wire logic             sda_o,
	input wire logic             sda_oe_n_o,
	input wire logic [DAC_W-1:0] dac_value_o,
	input wire logic             dac_update_o
);
	property p_pin; @(posedge link_clk_i) disable iff (!reset_n_i)
		sda_o == 1'b0; endproperty
	a_pin: assert property (p_pin) else $error("data pin not low");
	property p_line; @(posedge link_clk_i) disable iff (!reset_n_i)
		!sda_oe_n_o |-> !sda_i; endproperty
	a_line: assert property (p_line) else $error("line not held");
	// drive may only move while the clock line is low
	property p_edge; @(posedge link_clk_i) disable iff (!reset_n_i)
		$changed(sda_oe_n_o) |-> !scl_i; endproperty
	a_edge: assert property (p_edge) else $error("drive moved in high");
	property p_hold; @(posedge link_clk_i) disable iff (!reset_n_i)
		$fell(sda_oe_n_o) |=> !sda_oe_n_o [*7]; endproperty
	a_hold: assert property (p_hold) else $error("drive too short");
	property p_rst; @(posedge link_clk_i) disable iff (!reset_n_i)
		$rose(reset_n_i) |-> sda_oe_n_o; endproperty
	a_rst: assert property (p_rst) else $error("line held at reset");
	property p_rstv; @(posedge clk_i) disable iff (!reset_n_i)
		$rose(reset_n_i) |-> dac_value_o == DAC_RESET && !dac_update_o; endproperty
	a_rstv: assert property (p_rstv) else $error("bad reset value");
	property p_chg; @(posedge clk_i) disable iff (!reset_n_i)
		$changed(dac_value_o) |-> dac_update_o; endproperty
	a_chg: assert property (p_chg) else $error("silent change");
	property p_pulse; @(posedge clk_i) disable iff (!reset_n_i)
		dac_update_o |=> !dac_update_o; endproperty
	a_pulse: assert property (p_pulse) else $error("long update");
endmodule
bind i2c_slave_bus_recovery dac_i2c_checker dac_i2c_checker_i (
	.clk_i(clk_i), .reset_n_i(reset_n_i), .link_clk_i(link_clk_i),
	.scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
	.dac_value_o(dac_value_o), .dac_update_o(dac_update_o));

// *** test/i2c_master_model.sv ***
`timescale 1ns/1ps
module i2c_master_model (
	// bus lines, a released line reads high
	output logic      scl_o,
	output logic      sda_o,
	input  wire logic sda_i
);
	localparam int Q = 5000;
	// clock stands high outside frames
	initial scl_o = 1'b1;
	initial sda_o = 1'b1;
	task automatic start();
		sda_o = 1'b1;
		#Q scl_o = 1'b1;
		#Q sda_o = 1'b0;
		#Q scl_o = 1'b0;
		#Q;
	endtask
	task automatic stop();
		sda_o = 1'b0;
		#Q scl_o = 1'b1;
		#Q sda_o = 1'b1;
		#Q;
	endtask
	// nine bits msb first, a 1 releases the line
	task automatic xfer(input logic [8:0] d, output logic [8:0] q);
		for (int i = 8; i >= 0; i--) begin
			sda_o = d[i];
			#Q scl_o = 1'b1;
			#Q q[i] = sda_i;
			#Q scl_o = 1'b0;
			#Q;
		end
	endtask
endmodule

// *** test/tb_i2c_slave_bus_recovery.sv ***
`timescale 1ns/1ps
module tb_i2c_slave_bus_recovery;
	import dac_i2c_pkg::*;
	logic             clk_i = 1'b0;
	logic             link_clk_i = 1'b0;
	logic             reset_n_i = 1'b0;
	logic             scl;
	logic             m_sda;
	logic             sda_oe_n_o;
	logic             sda_o;
	logic             dac_update_o;
	logic [DAC_W-1:0] dac_value_o;
	logic [8:0]       r;
	int               num_errors = 0;
	int               n_tests = 0;
	int               n_upd = 0;
	int               n_bits = 0;
	int               b0;
	int               u0;
	// pull-up: high unless a party pulls low
	wire logic sda = sda_oe_n_o ? m_sda : sda_o;
	always #50 clk_i = ~clk_i;
	always #80 link_clk_i = ~link_clk_i;
	// one count per clock low phase, which covers every start, plus one per stop
	always @(negedge scl) n_bits++;
	always @(posedge sda) if (scl === 1'b1) n_bits++;
	always @(posedge clk_i) if (dac_update_o === 1'b1) n_upd++;
	i2c_slave_bus_recovery i2c_slave_bus_recovery_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
		.link_clk_i(link_clk_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
		.sda_oe_n_o(sda_oe_n_o), .dac_value_o(dac_value_o), .dac_update_o(dac_update_o));
	i2c_master_model m_i (.scl_o(scl), .sda_o(m_sda), .sda_i(sda));
	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("FAIL %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic mark();
		@(posedge clk_i);
		#5;
		b0 = n_bits;
		u0 = n_upd;
	endtask
	task automatic t_write();
		logic [8:0] w[4] = '{9'h0A9, 9'h001, 9'h02B, 9'h147};
		mark();
		m_i.start();
		foreach (w[i]) begin
			m_i.xfer(w[i], r);
			check(r & 9'h001, 9'h000);
		end
		m_i.stop();
		check({2'b00, dac_value_o}, 9'h023);
		check(9'(n_upd - u0), 9'h002);
		check(9'(n_bits - b0), 9'(20 + 2 * 9));
		$display("t_write done");
	endtask
	task automatic t_read(input logic [6:0] v, input int n);
		mark();
		m_i.start();
		m_i.xfer(9'h0A9, r);
		m_i.xfer(9'h001, r);
		m_i.start();
		m_i.xfer(9'h0AB, r);
		check(r & 9'h001, 9'h000);
		// master acknowledges all but the last byte; each repeats the value
		for (int k = 1; k < n; k++) begin
			m_i.xfer(9'h1FE, r);
			check(r, {1'b0, v, 1'b0});
		end
		m_i.xfer(9'h1FF, r);
		check(r, {1'b0, v, 1'b1});
		check({8'h00, sda_oe_n_o}, 9'h001);
		m_i.stop();
		check(9'(n_bits - b0), 9'(39 + 9 * (n - 1)));
		$display("t_read done");
	endtask
	task automatic t_abort();
		mark();
		m_i.start();
		m_i.xfer(9'h0A9, r);
		m_i.xfer(9'h001, r);
		m_i.xfer(9'h0FF, r);
		m_i.start();
		m_i.xfer(9'h0AD, r);
		check(r & 9'h001, 9'h001);
		m_i.xfer(9'h0A9, r);
		check(r & 9'h001, 9'h001);
		m_i.stop();
		check({2'b00, dac_value_o}, 9'h023);
		check(9'(n_upd - u0), 9'h000);
		$display("t_abort done");
	endtask
	task automatic t_recover();
		mark();
		m_i.start();
		m_i.xfer(9'h0AB, r);
		check({8'h00, sda_oe_n_o}, 9'h000);
		m_i.start();
		m_i.xfer(9'h1FF, r);
		m_i.start();
		m_i.stop();
		check({8'h00, sda_oe_n_o}, 9'h001);
		check({2'b00, dac_value_o}, 9'h023);
		check(9'(n_upd - u0), 9'h000);
		$display("t_recover done");
	endtask
	task automatic end_of_test();
		$display("errors %0d checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		// the scenarios need under 5 ms
		#8_000_000;
		num_errors++;
		end_of_test();
	end
	initial begin
		repeat (16) @(posedge clk_i);
		#5 reset_n_i = 1'b1;
		t_write();
		t_read(7'h23, 1);
		t_abort();
		t_recover();
		t_read(7'h23, 2);
		mark();
		reset_n_i = 1'b0;
		repeat (16) @(posedge clk_i);
		check({1'b0, sda_oe_n_o, dac_value_o}, 9'h080);
		#5 reset_n_i = 1'b1;
		repeat (2) @(posedge clk_i);
		#5;
		check({1'b0, sda_oe_n_o, dac_value_o}, 9'h080);
		// the interface must answer again and read back the reset value
		t_read(DAC_RESET, 1);
		$display("t_reset done");
		end_of_test();
	end
endmodule
